// file: src/adc_test_consts.svh
/*
 * Constants for the output coding and test pattern back end.
 * Assumes inclusion by the package only; the design file uses its macros without including it.
 */
`ifndef ADC_TEST_CONSTS_SVH
`define ADC_TEST_CONSTS_SVH

// register indices, byte address is four times the index
`define IDX_TESTMODE 10'h00d
`define IDX_USER1LO 10'h019
`define IDX_USER1HI 10'h01a
`define IDX_USER2LO 10'h01b
`define IDX_USER2HI 10'h01c
`define IDX_CLOCK 10'h009
`define IDX_FORMAT 10'h014
`define IDX_LANE 10'h021
`define IDX_STATUS 10'h020

// test mode register fields
`define TM_CODE_HI 3
`define TM_LONGRST 4
`define TM_SHORTRST 5

// fixed pattern words
`define W_MID 16'h8000
`define W_CHK1 16'haaaa
`define W_CHK2 16'h5555
`define W_TOG1 16'hfffc
`define W_ZERO 16'h0000
`define W_BITTOG 16'haaa8
`define W_SYNC 16'h01fc
`define W_ONEBIT 16'h8000
`define W_MIXED 16'ha19c

// prbs seeds and bits per word
`define PN9_SEED 9'h1ff
`define LONG_PRBS_SEED 23'h7fffff
`define PN_BITS 14

// strap settle time after reset release, in clocks
`define STRAP_WAIT 2'd3

`endif

// file: src/adc_test_pkg.sv
/*
 * Types for the output coding and test pattern back end.
 * Assumes the constants header sits beside it.
 */
package adc_test_pkg;
`include "adc_test_consts.svh"

    // test pattern codes
    typedef enum logic [3:0] {
        PAT_OFF = 4'h0, PAT_MID = 4'h1, PAT_POSFS = 4'h2,
        PAT_NEGFS = 4'h3, PAT_CHECK = 4'h4, PAT_PNLONG = 4'h5,
        PAT_PNSHORT = 4'h6, PAT_WTOG = 4'h7, PAT_USER = 4'h8,
        PAT_BTOG = 4'h9, PAT_SYNC = 4'ha, PAT_ONEBIT = 4'hb,
        PAT_MIXED = 4'hc
    } pat_t;

    // serializer states, one-hot
    typedef enum logic [1:0] {
        SER_IDLE = 2'b01,
        SER_SHIFT = 2'b10
    } ser_t;
endpackage

// file: src/adc_output_coding.sv
/*
 * Output coding and test pattern back end with its word FIFO.
 * Assumes an APB master on mclk, a sample clock and converter word
 * arriving from outside the mclk domain, and straps on pins.
 */
`timescale 1ns/1ps

// ----------------------------------------
// word fifo
// ----------------------------------------
module word_fifo #(
    parameter int Width = 16,
    parameter int Depth = 8
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic inValid,
    output logic inReady,
    input wire logic [Width-1:0] inData,
    output logic outValid,
    input wire logic outReady,
    output logic [Width-1:0] outData
);
    localparam int AW = $clog2(Depth);
    logic [Width-1:0] mem_q [Depth];
    logic [AW-1:0] wrPtr_q;
    logic [AW-1:0] rdPtr_q;
    logic [AW:0] count_q;
    wire doPush = inValid && inReady;
    wire doPop = outValid && outReady;

    assign inReady = (count_q != Depth[AW:0]);
    assign outValid = (count_q != '0);
    assign outData = mem_q[rdPtr_q];

    // pointers and fill count
    always_ff @(posedge mclk) begin
        if (rst) begin
            wrPtr_q <= '0;
            rdPtr_q <= '0;
            count_q <= '0;
        end else begin
            if (doPush) begin
                mem_q[wrPtr_q] <= inData;
                wrPtr_q <= (wrPtr_q == AW'(Depth - 1)) ? '0 : wrPtr_q + 1'b1;
            end
            if (doPop) begin
                rdPtr_q <= (rdPtr_q == AW'(Depth - 1)) ? '0 : rdPtr_q + 1'b1;
            end
            count_q <= count_q + {{AW{1'b0}}, doPush}
                - {{AW{1'b0}}, doPop};
        end
    end
endmodule

// ----------------------------------------
// output coding top
// ----------------------------------------
module adc_output_coding
    import adc_test_pkg::*;
#(
    parameter int FifoDepth = 8
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic sampleClk,
    input wire logic [15:0] sampleData,
    input wire logic portSelectN,
    input wire logic serialClkPatternStrap,
    input wire logic serialIoLaneStrap,
    output logic serialIoLaneStrapOut,
    output logic serialIoLaneStrapOe,
    output logic laneData0,
    output logic laneData1,
    output logic bitClockOut,
    output logic frameClockOut,
    output logic dutyCycleStabilizer,
    output logic dualLane
);
    // prbs word plus next state
    function automatic logic [22:0] pn9Run(input logic [8:0] s);
        logic [8:0] st;
        logic [13:0] b;
        st = s;
        b = '0;
        for (int i = 0; i < `PN_BITS; i++) begin
            b = {b[12:0], st[8]};
            st = {st[7:0], st[8] ^ st[4]};
        end
        return {b, st};
    endfunction

    // long prbs, bits reversed against the usual polarity
    function automatic logic [36:0] pn23Run(input logic [22:0] s);
        logic [22:0] st;
        logic [13:0] b;
        st = s;
        b = '0;
        for (int i = 0; i < `PN_BITS; i++) begin
            b = {b[12:0], ~st[22]};
            st = {st[21:0], st[22] ^ st[17]};
        end
        return {b, st};
    endfunction

    // format selection: flips the sign bit when asked
    function automatic logic [15:0] flipMsb(input logic [15:0] w,
                                            input logic doFlip);
        return {w[15] ^ doFlip, w[14:0]};
    endfunction

    // ----------------------------------------
    // input synchronisers
    // ----------------------------------------
    logic [3:0] pinA_q, pinB_q;
    logic [15:0] dataA_q, dataB_q;
    logic sclkPrev_q;
    always_ff @(posedge mclk) begin
        if (rst) begin
            pinA_q <= '0;
            pinB_q <= '0;
            sclkPrev_q <= 1'b0;
        end else begin
            pinA_q <= {sampleClk, portSelectN, serialClkPatternStrap,
                serialIoLaneStrap};
            pinB_q <= pinA_q;
            sclkPrev_q <= pinB_q[3];
        end
    end
    always_ff @(posedge mclk) begin
        dataA_q <= sampleData;
        dataB_q <= dataA_q;
    end
    wire sampleRise = pinB_q[3] && !sclkPrev_q;
    wire portOff = pinB_q[2];
    wire patStrapS = pinB_q[1];
    wire laneStrapS = pinB_q[0];

    // ----------------------------------------
    // strap capture after reset release
    // ----------------------------------------
    logic [1:0] strapCnt_q;
    logic strapDone_q, strapTest_q, laneStrap_q;
    wire strapTake = !strapDone_q && (strapCnt_q == `STRAP_WAIT);
    always_ff @(posedge mclk) begin
        if (rst) begin
            strapCnt_q <= '0;
            strapDone_q <= 1'b0;
            strapTest_q <= 1'b0;
            laneStrap_q <= 1'b1;
        end else if (!strapDone_q) begin
            strapCnt_q <= strapCnt_q + 2'd1;
            if (strapTake) begin
                strapDone_q <= 1'b1;
                strapTest_q <= portOff && patStrapS;
                laneStrap_q <= laneStrapS;
            end
        end
    end

    // ----------------------------------------
    // apb slave
    // ----------------------------------------
    logic [5:0] testMode_q;
    logic [7:0] user1Lo_q, user1Hi_q, user2Lo_q, user2Hi_q;
    logic offsetBin_q, dcs_q, laneCtl_q, spiSeen_q;
    logic [31:0] rdata_q;
    logic ready_q, err_q;
    wire setup = psel && !penable;
    wire [9:0] idx = paddr[11:2];
    wire hitTm = idx == `IDX_TESTMODE;
    wire hitU1l = idx == `IDX_USER1LO;
    wire hitU1h = idx == `IDX_USER1HI;
    wire hitU2l = idx == `IDX_USER2LO;
    wire hitU2h = idx == `IDX_USER2HI;
    wire hitClk = idx == `IDX_CLOCK;
    wire hitFmt = idx == `IDX_FORMAT;
    wire hitLane = idx == `IDX_LANE;
    wire hitSt = idx == `IDX_STATUS;
    wire hitAny = hitTm || hitU1l || hitU1h || hitU2l || hitU2h
        || hitClk || hitFmt || hitLane || hitSt;
    // writes ignored while select held high
    // write lands at the access edge where pready is seen high
    wire wrOk = psel && penable && ready_q && pwrite && !portOff
        && paddr[1:0] == 2'b00;
    logic [31:0] rdMux;
    always_comb begin
        if (hitTm) rdMux = {26'h0, testMode_q};
        else if (hitU1l) rdMux = {24'h0, user1Lo_q};
        else if (hitU1h) rdMux = {24'h0, user1Hi_q};
        else if (hitU2l) rdMux = {24'h0, user2Lo_q};
        else if (hitU2h) rdMux = {24'h0, user2Hi_q};
        else if (hitClk) rdMux = {31'h0, dcs_q};
        else if (hitFmt) rdMux = {31'h0, offsetBin_q};
        else if (hitLane) rdMux = {31'h0, laneCtl_q};
        else if (hitSt) rdMux = {27'h0, strapTest_q, laneStrap_q,
            portOff, spiSeen_q};
        else rdMux = 32'h0;
    end

    // answer in the cycle after setup
    always_ff @(posedge mclk) begin
        if (rst) begin
            ready_q <= 1'b0;
            err_q <= 1'b0;
            rdata_q <= '0;
        end else begin
            ready_q <= setup;
            err_q <= setup && !hitAny;
            rdata_q <= (setup && !pwrite) ? rdMux : 32'h0;
        end
    end

    // register writes
    always_ff @(posedge mclk) begin
        if (rst) begin
            testMode_q <= '0;
            user1Lo_q <= '0;
            user1Hi_q <= '0;
            user2Lo_q <= '0;
            user2Hi_q <= '0;
            dcs_q <= 1'b1;
            offsetBin_q <= 1'b0;
            laneCtl_q <= 1'b1;
            spiSeen_q <= 1'b0;
        end else if (wrOk) begin
            spiSeen_q <= 1'b1;
            if (hitTm) testMode_q <= pwdata[5:0];
            if (hitU1l) user1Lo_q <= pwdata[7:0];
            if (hitU1h) user1Hi_q <= pwdata[7:0];
            if (hitU2l) user2Lo_q <= pwdata[7:0];
            if (hitU2h) user2Hi_q <= pwdata[7:0];
            if (hitClk) dcs_q <= pwdata[0];
            if (hitFmt) offsetBin_q <= pwdata[0];
            if (hitLane) laneCtl_q <= pwdata[0];
        end
    end

    // ----------------------------------------
    // pattern generation
    // ----------------------------------------
    logic [8:0] pn9_q;
    logic [22:0] long_prbs_q;
    logic altSel_q;
    logic [15:0] pushWord;
    wire [3:0] code = testMode_q[`TM_CODE_HI:0];
    wire [22:0] pn9Nx = pn9Run(pn9_q);
    wire [36:0] pn23Nx = pn23Run(long_prbs_q);
    wire [15:0] user1 = {user1Hi_q, user1Lo_q};
    wire [15:0] user2 = {user2Hi_q, user2Lo_q};
    wire fifoReady;
    // one word per sample edge, edge skipped while fifo is full
    wire pushEn = sampleRise && fifoReady && strapDone_q;

    always_comb begin
        if (strapTest_q) pushWord = `W_MID;
        else case (pat_t'(code))
            PAT_OFF: pushWord = flipMsb(dataB_q, !offsetBin_q);
            PAT_MID, PAT_POSFS, PAT_NEGFS:
                pushWord = flipMsb(`W_MID, !offsetBin_q);
            PAT_CHECK: pushWord = altSel_q ? `W_CHK2 : `W_CHK1;
            PAT_PNLONG:
                pushWord = flipMsb({pn23Nx[36:23], 2'b00}, offsetBin_q);
            PAT_PNSHORT:
                pushWord = flipMsb({pn9Nx[22:9], 2'b00}, offsetBin_q);
            PAT_WTOG: pushWord = altSel_q ? `W_ZERO : `W_TOG1;
            PAT_USER: pushWord = altSel_q ? user2 : user1;
            PAT_BTOG: pushWord = `W_BITTOG;
            PAT_SYNC: pushWord = `W_SYNC;
            PAT_ONEBIT: pushWord = `W_ONEBIT;
            PAT_MIXED: pushWord = `W_MIXED;
            default: pushWord = `W_ZERO;
        endcase
    end

    // generators, held at seed while a reset bit is set
    always_ff @(posedge mclk) begin
        if (rst || testMode_q[`TM_LONGRST] || testMode_q[`TM_SHORTRST]) begin
            pn9_q <= `PN9_SEED;
            long_prbs_q <= `LONG_PRBS_SEED;
            altSel_q <= 1'b0;
        end else if (pushEn) begin
            if (code == PAT_PNSHORT) pn9_q <= pn9Nx[8:0];
            if (code == PAT_PNLONG) long_prbs_q <= pn23Nx[22:0];
            altSel_q <= !altSel_q;
        end
    end

    wire fifoValid;
    wire [15:0] fifoData;
    logic popEn;
    word_fifo #(.Width(16), .Depth(FifoDepth)) u_fifo (
        .mclk(mclk),
        .rst(rst),
        .inValid(pushEn),
        .inReady(fifoReady),
        .inData(pushWord),
        .outValid(fifoValid),
        .outReady(popEn),
        .outData(fifoData)
    );

    // ----------------------------------------
    // serializer
    // ----------------------------------------
    ser_t ser_q;
    logic [15:0] shift_q;
    logic [3:0] bitCnt_q;
    logic lane0_q, lane1_q, bclk_q, fclk_q, dual_q;
    // strap picks lanes while the port is off
    wire dualSel = portOff ? laneStrap_q : laneCtl_q;
    wire [3:0] lastBit = dual_q ? 4'd7 : 4'd15;
    assign popEn = (ser_q == SER_IDLE) && fifoValid;
    always_ff @(posedge mclk) begin
        if (rst) begin
            ser_q <= SER_IDLE;
            shift_q <= '0;
            bitCnt_q <= '0;
            lane0_q <= 1'b0;
            lane1_q <= 1'b0;
            fclk_q <= 1'b0;
            dual_q <= 1'b1;
        end else begin
            case (ser_q)
                SER_IDLE: begin
                    fclk_q <= 1'b0;
                    if (fifoValid) begin
                        shift_q <= fifoData;
                        bitCnt_q <= '0;
                        dual_q <= dualSel;
                        ser_q <= SER_SHIFT;
                    end
                end
                SER_SHIFT: begin
                    lane0_q <= shift_q[15];
                    lane1_q <= dual_q ? shift_q[7] : 1'b0;
                    shift_q <= dual_q ? {shift_q[14:8], 1'b0,
                        shift_q[6:0], 1'b0} : {shift_q[14:0], 1'b0};
                    fclk_q <= bitCnt_q < (dual_q ? 4'd4 : 4'd8);
                    bitCnt_q <= bitCnt_q + 4'd1;
                    if (bitCnt_q == lastBit)
                        ser_q <= SER_IDLE;
                end
                default: ser_q <= SER_IDLE;
            endcase
        end
    end

    // bit clock, port pins and straps
    logic ioOe_q, dcsOut_q;
    always_ff @(posedge mclk) begin
        if (rst) begin
            bclk_q <= 1'b0;
            ioOe_q <= 1'b0;
            dcsOut_q <= 1'b1;
        end else begin
            bclk_q <= !bclk_q;
            ioOe_q <= 1'b0;
            // forced on until the port is used
            dcsOut_q <= (portOff && !spiSeen_q) ? 1'b1 : dcs_q;
        end
    end

    assign prdata = rdata_q;
    assign pready = ready_q;
    assign pslverr = err_q;
    assign laneData0 = lane0_q;
    assign laneData1 = lane1_q;
    assign bitClockOut = bclk_q;
    assign frameClockOut = fclk_q;
    assign serialIoLaneStrapOut = 1'b0;
    assign serialIoLaneStrapOe = ioOe_q;
    assign dutyCycleStabilizer = dcsOut_q;
    assign dualLane = dual_q;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    chk_fmt_twos: assert property (
        pushEn && !strapTest_q && code == PAT_OFF && !offsetBin_q
        |-> pushWord == {~dataB_q[15], dataB_q[14:0]})
        else $error("normal word not in two's complement");
    chk_bit_toggle: assert property (
        pushEn && !strapTest_q && code == PAT_BTOG
        |-> pushWord == 16'haaa8)
        else $error("bit toggle word wrong");
    chk_short_fixed: assert property (
        pushEn && !strapTest_q && code == PAT_NEGFS
        |-> pushWord == (offsetBin_q ? 16'h8000 : 16'h0000))
        else $error("short fixed word wrong");
    chk_checker_alt: assert property (
        pushEn && !strapTest_q && code == PAT_CHECK && !altSel_q
        |-> pushWord == 16'haaaa ##1 altSel_q)
        else $error("checkerboard did not alternate");
    chk_wtog_bypass: assert property (
        pushEn && !strapTest_q && code == PAT_WTOG && altSel_q
        |-> pushWord == 16'h0000)
        else $error("word toggle second word wrong");
    chk_user_word: assert property (
        pushEn && !strapTest_q && code == PAT_USER
        |-> pushWord == (altSel_q ? user2 : user1))
        else $error("user word wrong");
    chk_pn_reseed: assert property (
        testMode_q[`TM_SHORTRST] |=> pn9_q == 9'h1ff && long_prbs_q == 23'h7fffff)
        else $error("prbs not reseeded");
    chk_pn9_advance: assert property (
        pushEn && code == PAT_PNSHORT && testMode_q[5:4] == 2'b00
        |=> pn9_q != $past(pn9_q))
        else $error("short prbs did not advance");
    chk_strap_word: assert property (
        pushEn && strapTest_q |-> pushWord == 16'h8000)
        else $error("strap test word wrong");
    chk_port_float: assert property (
        portOff |=> !serialIoLaneStrapOe && $stable(testMode_q))
        else $error("port active while deselected");
    chk_dcs_default: assert property (
        portOff && !spiSeen_q |=> dutyCycleStabilizer)
        else $error("stabilizer off under strap control");
    chk_lane_strap: assert property (
        ser_q == SER_IDLE && fifoValid && portOff |=> dualLane == laneStrap_q)
        else $error("lane mode not from strap");

    cov_user_mode: cover property (pushEn && code == PAT_USER
        ##[1:16] pushEn);
    cov_pn_long: cover property (pushEn && code == PAT_PNLONG);
    cov_fifo_full: cover property (sampleRise && !fifoReady);
    cov_single_lane: cover property (ser_q == SER_SHIFT && !dual_q);
endmodule

// file: bench/lane_receiver.sv
/*
 * Receiver model for the serial lanes: rebuilds 16-bit words.
 * Assumes one lane bit per mclk, msb first, word start on frame rise.
 */
`timescale 1ns/1ps

// ----------------------------------------
// lane receiver
// ----------------------------------------
module lane_receiver (
    input wire logic mclk,
    input wire logic rst,
    input wire logic laneData0,
    input wire logic laneData1,
    input wire logic frameClockOut,
    input wire logic dualLane,
    output logic [15:0] word,
    output logic wordValid
);
    logic framePrev;
    logic [15:0] hi, lo;
    int cnt;

    always @(posedge mclk) begin
        wordValid <= 1'b0;
        framePrev <= frameClockOut;
        if (rst) begin
            cnt = 0;
        end else if ((frameClockOut && !framePrev) || cnt != 0) begin
            hi = {hi[14:0], laneData0};
            lo = {lo[14:0], laneData1};
            cnt++;
            // eight bits per lane when dual
            if (cnt == (dualLane ? 8 : 16)) begin
                word <= dualLane ? {hi[7:0], lo[7:0]} : hi;
                wordValid <= 1'b1;
                cnt = 0;
            end
        end
    end
endmodule

// file: bench/adc_output_coding_tb_top.sv
/*
 * Bench for the output coding back end: registers, patterns, straps.
 * Assumes the design package and the lane receiver model.
 */
`timescale 1ns/1ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin n_mismatch++; \
    $display("wrong value at %0t: %h not %h", $time, a, b); end end

module adc_output_coding_tb_top
    import adc_test_pkg::*;
;
    logic mclk, rst, psel, penable, pwrite, pready, pslverr, rerr;
    logic sampleClk, portSelectN, patStrap, laneStrap, strapOut, strapOe;
    logic lane0, lane1, bitClk, frameClk, duty_cycle_stabilizer, dualLane, rxValid;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdat;
    logic [15:0] sampleData, rxWord;
    logic [15:0] rx[$];
    logic [2:0] sdiv;
    int checks = 0;
    int n_mismatch = 0;
    int cyc = 0;

    adc_output_coding #(.FifoDepth(8)) i_dut (.mclk(mclk), .rst(rst),
        .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .sampleClk(sampleClk), .sampleData(sampleData),
        .portSelectN(portSelectN), .serialClkPatternStrap(patStrap),
        .serialIoLaneStrap(laneStrap), .serialIoLaneStrapOut(strapOut),
        .serialIoLaneStrapOe(strapOe), .laneData0(lane0),
        .laneData1(lane1), .bitClockOut(bitClk),
        .frameClockOut(frameClk), .dutyCycleStabilizer(duty_cycle_stabilizer),
        .dualLane(dualLane));
    lane_receiver i_rx (.mclk(mclk), .rst(rst), .laneData0(lane0),
        .laneData1(lane1), .frameClockOut(frameClk), .dualLane(dualLane),
        .word(rxWord), .wordValid(rxValid));

    // ----------------------------------------
    // clocks, words and timeout
    // ----------------------------------------
    always #12.5 mclk = ~mclk;
    // sample clock 200 ns, low rate
    always @(posedge mclk) begin
        sdiv <= sdiv + 3'd1;
        if (sdiv[1:0] == 2'd3) begin
            sampleClk <= ~sampleClk;
        end
        if (rxValid) begin
            rx.push_back(rxWord);
        end
        cyc <= cyc + 1;
        if (cyc == 80000) begin
            n_mismatch++;
            finish_test();
        end
    end

    task automatic finish_test();
        $display("checks %0d n_mismatch %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do begin
            @(posedge mclk);
        end while (pready !== 1'b1);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic settle(input int w, input int k);
        int n = 0;
        repeat (w) @(posedge mclk);
        rx.delete();
        while (rx.size() < k && n < 3000) begin
            @(posedge mclk);
            n++;
        end
    endtask

    task automatic doReset(input logic ps, input logic pat, input logic ls);
        @(posedge mclk);
        rst <= 1'b1;
        portSelectN <= ps;
        patStrap <= pat;
        laneStrap <= ls;
        repeat (16) @(posedge mclk);
        rst <= 1'b0;
        repeat (6) @(posedge mclk);
    endtask

    function automatic logic [15:0] pnWord(input logic lng,
                                           inout logic [22:0] s);
        logic [13:0] w;
        logic nb;
        for (int i = 0; i < 14; i++) begin
            w = {w[12:0], lng ? ~s[22] : s[8]};
            nb = lng ? s[22] ^ s[17] : s[8] ^ s[4];
            s = lng ? {s[21:0], nb} : {14'h0, s[7:0], nb};
        end
        return {w, 2'b00};
    endfunction

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    // reset state and stabilizer control
    task automatic t_reset();
        logic b;
        b = bitClk;
        @(posedge mclk);
        `CHK(bitClk, ~b)
        `CHK(strapOut, 1'b0)
        `CHK(duty_cycle_stabilizer, 1'b1)
        `CHK(dualLane, 1'b1)
        `CHK(strapOe, 1'b0)
        apb(1'b1, 12'h024, 32'h0);
        repeat (2) @(posedge mclk);
        `CHK(duty_cycle_stabilizer, 1'b0)
        apb(1'b0, 12'h3fc, 32'h0);
        `CHK(rerr, 1'b1)
        `CHK(rdat, 32'h0)
    endtask

    task automatic t_normal();
        logic [15:0] ins[3] = '{16'h8000, 16'hffff, 16'h0000};
        for (int f = 0; f < 2; f++) begin
            if (f) begin
                apb(1'b1, 12'h050, 32'h1);
            end
            for (int i = 0; i < 3; i++) begin
                @(posedge mclk);
                sampleData <= ins[i];
                settle(250, 2);
                `CHK(rx[1], ins[i] ^ (f ? 16'h0 : 16'h8000))
            end
        end
    endtask

    task automatic t_fixed();
        pat_t c[7] = '{PAT_MID, PAT_POSFS, PAT_NEGFS, PAT_BTOG, PAT_SYNC,
                       PAT_ONEBIT, PAT_MIXED};
        logic [15:0] w[7] = '{16'h0, 16'h0, 16'h0, 16'haaa8, 16'h01fc,
                              16'h8000, 16'ha19c};
        @(posedge mclk);
        sampleData <= 16'h1234;
        for (int f = 1; f >= 0; f--) begin
            apb(1'b1, 12'h050, 32'(f));
            for (int i = 0; i < 7; i++) begin
                apb(1'b1, 12'h034, {28'h0, c[i]});
                settle(250, 3);
                `CHK(rx[2], w[i] ^ (f && i < 3 ? 16'h8000 : 16'h0))
            end
        end
    endtask

    task automatic t_alt();
        pat_t c[3] = '{PAT_CHECK, PAT_WTOG, PAT_USER};
        logic [15:0] a[3] = '{16'haaaa, 16'hfffc, 16'h1234};
        logic [15:0] b[3] = '{16'h5555, 16'h0000, 16'habcd};
        apb(1'b1, 12'h064, 32'h34);
        apb(1'b1, 12'h068, 32'h12);
        apb(1'b1, 12'h06c, 32'hcd);
        apb(1'b1, 12'h070, 32'hab);
        apb(1'b0, 12'h06c, 32'h0);
        `CHK(rdat[7:0], 8'hcd)
        apb(1'b1, 12'h050, 32'h1);
        for (int i = 0; i < 3; i++) begin
            apb(1'b1, 12'h034, {28'h0, c[i]});
            settle(250, 6);
            `CHK(rx[0] === a[i] || rx[0] === b[i], 1'b1)
            for (int j = 1; j < 6; j++) begin
                `CHK(rx[j], rx[j-1] === a[i] ? b[i] : a[i])
            end
        end
    endtask

    task automatic t_prbs();
        logic [22:0] s;
        logic [15:0] e[3];
        logic hit;
        apb(1'b1, 12'h050, 32'h0);
        for (int p = 0; p < 2; p++) begin
            s = p ? 23'h7fffff : 23'h1ff;
            for (int i = 0; i < 3; i++) begin
                e[i] = pnWord(p[0], s);
            end
            apb(1'b1, 12'h034, p ? 32'h15 : 32'h26);
            repeat (250) @(posedge mclk);
            apb(1'b1, 12'h034, p ? 32'h5 : 32'h6);
            settle(0, 30);
            hit = 1'b0;
            for (int i = 0; i < rx.size() - 2; i++) begin
                if (rx[i] === e[0] && rx[i+1] === e[1] && rx[i+2] === e[2])
                    hit = 1'b1;
            end
            `CHK(hit, 1'b1)
        end
    endtask

    task automatic t_strap();
        doReset(1'b1, 1'b1, 1'b0);
        apb(1'b1, 12'h034, 32'h4);
        settle(250, 4);
        `CHK(dualLane, 1'b0)
        `CHK(duty_cycle_stabilizer, 1'b1)
        `CHK(strapOe, 1'b0)
        for (int i = 0; i < 4; i++) begin
            `CHK(rx[i], 16'h8000)
        end
    endtask

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        mclk = 1'b0;
        rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h0;
        pwdata = 32'h0;
        sampleClk = 1'b0;
        sdiv = 3'h0;
        sampleData = 16'h0;
        portSelectN = 1'b0;
        patStrap = 1'b0;
        laneStrap = 1'b1;
        doReset(1'b0, 1'b0, 1'b1);
        t_reset();
        t_normal();
        t_fixed();
        t_alt();
        t_prbs();
        t_strap();
        finish_test();
    end
endmodule
